// ### hw/aab_core.sv
`timescale 1ns/100ps
`include "aab_map.svh"
module aab_core (
  input  wire logic                CORE_CLK,     // instruction clock, 200 MHz
  input  wire logic                RESETN,       // async reset, active low
  input  wire aab_pkg::aab_instr_t INSTR,        // decoded instruction
  input  wire logic [7:0]          FILE_RDATA,   // file register read data at INSTR.addr
  input  wire logic                FILE_IS_PORT, // addressed file is an I/O port
  input  wire logic [7:0]          PIN_LEVELS,   // pin levels of the addressed port
  output aab_pkg::aab_fwrite_t     FILE_WR,      // file register write-back
  output logic [7:0]               ACC,          // working accumulator
  output aab_pkg::aab_flags_t      FLAGS,        // zero, half carry, carry
  output logic                     SQUASH        // next instruction runs as no-op
);
  // ****************************************************************
  // operand selection
  // ****************************************************************
  logic [7:0] file_src;
  logic [7:0] add_b;
  logic [7:0] add_sum;
  logic       add_c;
  logic       add_hc;
  logic       tested;

  // port pins, not the output latch, feed the read-modify-write
  assign file_src = FILE_IS_PORT ? PIN_LEVELS : FILE_RDATA;  // [RQ10]
  assign add_b    = (INSTR.op == aab_pkg::AAB_OP_ADD_LIT) ? INSTR.literal : file_src;
  assign tested   = file_src[INSTR.bit_sel];

  aab_adder #(
    .WIDTH (8)
  ) u_adder (
    .a       (ACC),
    .b       (add_b),
    .sum     (add_sum),
    .carry   (add_c),
    .half_cy (add_hc)
  );

  // ****************************************************************
  // per-bit values for bit clear and bit set
  // ****************************************************************
  logic [7:0] clr_val;
  logic [7:0] set_val;

  // one cell per bit keeps the decode of bit_sel local to that bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign clr_val[gi] = (INSTR.bit_sel == 3'(gi)) ? 1'b0 : file_src[gi];  // [RQ6]
      assign set_val[gi] = (INSTR.bit_sel == 3'(gi)) ? 1'b1 : file_src[gi];  // [RQ7]
    end
  endgenerate

  // ****************************************************************
  // slot qualification
  // ****************************************************************
  logic       squash_ff;
  logic       nxt_squash;
  logic       live;
  logic       to_file;
  logic [7:0] and_res;

  // a squashed slot executes as a no-op whatever the decoder presents
  assign live    = INSTR.valid && !squash_ff;  // [RQ8]
  assign to_file = (INSTR.dest == `AAB_DEST_FILE);  // [RQ3]
  assign and_res = ACC & ((INSTR.op == aab_pkg::AAB_OP_AND_LIT) ? INSTR.literal : file_src);

  // ****************************************************************
  // accumulator and status flags
  // ****************************************************************
  logic [7:0]          acc_ff;
  logic [7:0]          nxt_acc;
  aab_pkg::aab_flags_t flags_ff;
  aab_pkg::aab_flags_t nxt_flags;

  always_comb begin
    nxt_acc   = acc_ff;
    nxt_flags = flags_ff;
    if (live) begin
      case (INSTR.op)
        aab_pkg::AAB_OP_ADD_LIT: begin
          nxt_acc      = add_sum;  // [RQ1]
          nxt_flags.c  = add_c;  // [RQ11]
          nxt_flags.hc = add_hc;
          nxt_flags.z  = (add_sum == 8'h00);
        end
        aab_pkg::AAB_OP_ADD_FILE: begin
          nxt_flags.c  = add_c;  // [RQ2]
          nxt_flags.hc = add_hc;
          nxt_flags.z  = (add_sum == 8'h00);  // [RQ11]
          if (!to_file) begin
            nxt_acc = add_sum;  // [RQ3]
          end
        end
        aab_pkg::AAB_OP_AND_LIT: begin
          nxt_acc     = and_res;  // [RQ4]
          nxt_flags.z = (and_res == 8'h00);
        end
        aab_pkg::AAB_OP_AND_FILE: begin
          // carry and half carry keep their values on a logical operation
          nxt_flags.z = (and_res == 8'h00);  // [RQ5]
          if (!to_file) begin
            nxt_acc = and_res;  // [RQ3]
          end
        end
        default: begin
          // bit operations and the skip test leave accumulator and flags alone
          nxt_acc   = acc_ff;  // [RQ6] [RQ7] [RQ9]
          nxt_flags = flags_ff;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_ff   <= `AAB_ACC_RST;
      flags_ff <= `AAB_FLAGS_RST;
    end else begin
      acc_ff   <= nxt_acc;
      flags_ff <= nxt_flags;
    end
  end

  // ****************************************************************
  // file register write-back
  // ****************************************************************
  aab_pkg::aab_fwrite_t fwr_ff;
  aab_pkg::aab_fwrite_t nxt_fwr;

  // no forwarding here: the caller reflects a write into the next read
  always_comb begin
    nxt_fwr = '{we: 1'b0, addr: INSTR.addr, data: 8'h00};
    if (live) begin
      case (INSTR.op)
        aab_pkg::AAB_OP_ADD_FILE: begin
          if (to_file) begin
            nxt_fwr.we   = 1'b1;  // [RQ3]
            nxt_fwr.data = add_sum;  // [RQ2]
          end
        end
        aab_pkg::AAB_OP_AND_FILE: begin
          if (to_file) begin
            nxt_fwr.we   = 1'b1;  // [RQ3]
            nxt_fwr.data = and_res;  // [RQ5]
          end
        end
        aab_pkg::AAB_OP_BIT_CLR: begin
          nxt_fwr.we   = 1'b1;
          nxt_fwr.data = clr_val;  // [RQ6]
        end
        aab_pkg::AAB_OP_BIT_SET: begin
          nxt_fwr.we   = 1'b1;
          nxt_fwr.data = set_val;  // [RQ7]
        end
        default: begin
          nxt_fwr.we = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fwr_ff <= '0;
    end else begin
      fwr_ff <= nxt_fwr;
    end
  end

  // ****************************************************************
  // conditional skip
  // ****************************************************************
  // the squash lasts one slot only, so two skips can never chain
  always_comb begin
    nxt_squash = 1'b0;
    if (live) begin
      case (INSTR.op)
        aab_pkg::AAB_OP_BIT_TEST: begin
          nxt_squash = !tested;  // [RQ8] [RQ9]
        end
        default: begin
          nxt_squash = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      squash_ff <= 1'b0;
    end else begin
      squash_ff <= nxt_squash;
    end
  end

  // ****************************************************************
  // outputs, each straight from a flip-flop
  // ****************************************************************
  assign ACC     = acc_ff;
  assign FLAGS   = flags_ff;
  assign FILE_WR = fwr_ff;
  assign SQUASH  = squash_ff;
endmodule

// ### hw/aab_map.svh
// Overview of operation
// [RQ1] add literal: accumulator plus 8-bit literal into accumulator, flags C, half carry, Z.
// [RQ2] add file: accumulator plus file register 0..127, flags C, half carry, Z.
// [RQ3] destination bit 0 writes accumulator, 1 writes back to the file register.
// [RQ4] and literal: accumulator AND literal into accumulator, only Z changes.
// [RQ5] and file: accumulator AND file register to destination, only Z changes.
// [RQ6] bit clear forces selected bit of file register to zero, flags untouched.
// [RQ7] bit set forces selected bit of file register to one, flags untouched.
// [RQ8] skip-if-clear with tested bit zero squashes next instruction into a no-op.
// [RQ9] skip-if-clear with tested bit one lets next run; no flags changed.
// [RQ10] read-modify-write of I/O port uses pin levels, not output latch.
// [RQ11] Z when result is zero; carry from bit 7, half carry from bit 3.
`ifndef AAB_MAP_SVH
`define AAB_MAP_SVH
`define AAB_ACC_RST      8'h00
`define AAB_FLAGS_RST    3'h0
`define AAB_DEST_ACC     1'b0
`define AAB_DEST_FILE    1'b1
`define AAB_FLAG_C_POS   0
`define AAB_FLAG_HC_POS  1
`define AAB_FLAG_Z_POS   2
`endif

// ### hw/aab_pkg.sv
package aab_pkg;
  typedef enum logic [2:0] {
    AAB_OP_NONE,
    AAB_OP_ADD_LIT,
    AAB_OP_ADD_FILE,
    AAB_OP_AND_LIT,
    AAB_OP_AND_FILE,
    AAB_OP_BIT_CLR,
    AAB_OP_BIT_SET,
    AAB_OP_BIT_TEST
  } aab_op_t;

  typedef struct packed {
    logic       valid;
    aab_op_t    op;
    logic [7:0] literal;
    logic [6:0] addr;
    logic       dest;
    logic [2:0] bit_sel;
  } aab_instr_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } aab_fwrite_t;

  typedef struct packed {
    logic z;
    logic hc;
    logic c;
  } aab_flags_t;
endpackage

// ### hw/aab_adder.sv
`timescale 1ns/100ps
module aab_adder #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] a,        // first operand
  input  wire logic [WIDTH-1:0] b,        // second operand
  output logic      [WIDTH-1:0] sum,      // result
  output logic                  carry,    // carry out of top bit
  output logic                  half_cy   // carry out of bit 3
);
  logic [4:0]       low;
  logic [WIDTH:0]   full;

  always_comb begin
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};  // [RQ11]
    full = {1'b0, a} + {1'b0, b};            // [RQ11]
    sum     = full[WIDTH-1:0];
    carry   = full[WIDTH];
    half_cy = low[4];
  end
endmodule

// ### tb/aab_core_assertions.sv
`timescale 1ns/100ps
module aab_core_assertions (
  input wire logic                 CORE_CLK,     // clock
  input wire logic                 RESETN,       // reset, active low
  input wire aab_pkg::aab_instr_t  INSTR,        // instruction
  input wire logic [7:0]           FILE_RDATA,   // file data
  input wire logic                 FILE_IS_PORT, // port select
  input wire logic [7:0]           PIN_LEVELS,   // pin levels
  input wire aab_pkg::aab_fwrite_t FILE_WR,      // write-back
  input wire logic [7:0]           ACC,          // accumulator
  input wire aab_pkg::aab_flags_t  FLAGS,        // flags
  input wire logic                 SQUASH        // skip
);
  logic [7:0] opnd, res, lgc, bitv;
  logic [2:0] op;
  logic       co;
  assign opnd = FILE_IS_PORT ? PIN_LEVELS : FILE_RDATA;
  // a squashed slot counts as no operation, so no check fires on it
  assign op = (INSTR.valid && !SQUASH) ? INSTR.op : 3'h0;
  assign {co, res} = ACC + (op == 3'h1 ? INSTR.literal : opnd);
  assign lgc = ACC & (op == 3'h3 ? INSTR.literal : opnd);
  assign bitv = op == 3'h6 ? opnd | (8'h01 << INSTR.bit_sel) : opnd & ~(8'h01 << INSTR.bit_sel);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_skip; SQUASH ##1 !SQUASH; endsequence
  a_add_lit: assert property (op == 3'h1 |=> ACC == $past(res) && FLAGS.c == $past(co))
    else $error("add literal wrong");
  a_add_file: assert property (op == 3'h2 |=> FLAGS.z == ($past(res) == 8'h00))
    else $error("add file flags wrong");
  a_dest_acc: assert property (op == 3'h2 && !INSTR.dest |=> ACC == $past(res))
    else $error("add file to acc wrong");
  a_file_wb: assert property (op == 3'h2 && INSTR.dest |=> FILE_WR.data == $past(res))
    else $error("add file write wrong");
  a_and_z: assert property (op == 3'h3 || op == 3'h4 |=> FLAGS.z == ($past(lgc) == 8'h00))
    else $error("and zero flag wrong");
  a_bit_ops: assert property (op == 3'h5 || op == 3'h6 |=> FILE_WR.data == $past(bitv))
    else $error("bit write wrong");
  a_skip_clr: assert property (op == 3'h7 && !opnd[INSTR.bit_sel] |=> s_skip)
    else $error("skip missing");
  a_skip_set: assert property (op == 3'h7 && opnd[INSTR.bit_sel] |=> !SQUASH && $stable(FLAGS))
    else $error("skip unexpected");
endmodule
bind aab_core aab_core_assertions u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .INSTR(INSTR),
  .FILE_RDATA(FILE_RDATA), .FILE_IS_PORT(FILE_IS_PORT), .PIN_LEVELS(PIN_LEVELS),
  .FILE_WR(FILE_WR), .ACC(ACC), .FLAGS(FLAGS), .SQUASH(SQUASH));

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic                 CORE_CLK = 1'b0, RESETN = 1'b0, FILE_IS_PORT = 1'b0, SQUASH;
  logic [7:0]           FILE_RDATA = 8'h00, PIN_LEVELS = 8'h00, ACC;
  aab_pkg::aab_instr_t  INSTR = '0;
  aab_pkg::aab_fwrite_t FILE_WR;
  aab_pkg::aab_flags_t  FLAGS;
  int                   errors = 0, checks_done = 0;
  always #2.5 CORE_CLK = ~CORE_CLK;
  aab_core dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA),
    .FILE_IS_PORT(FILE_IS_PORT), .PIN_LEVELS(PIN_LEVELS), .FILE_WR(FILE_WR), .ACC(ACC),
    .FLAGS(FLAGS), .SQUASH(SQUASH));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // m = {port, dest, bit}; the unused source gets the inverse so a wrong pick shows
  task automatic step(input logic [2:0] op, input logic [7:0] v, input logic [6:0] a,
                      input logic [4:0] m, input logic [7:0] ea, input logic [3:0] ef,
                      input logic [15:0] ew);
    @(negedge CORE_CLK);
    INSTR = {1'b1, op, v, a, m[3:0]};
    FILE_IS_PORT = m[4];
    PIN_LEVELS = m[4] ? v : ~v;
    FILE_RDATA = m[4] ? ~v : v;
    @(posedge CORE_CLK) #1;
    chk("acc", {8'h00, ea}, {8'h00, ACC});
    chk("skip_flags", {12'h000, ef}, {12'h000, SQUASH, FLAGS});
    chk("file_wr", ew, FILE_WR.we ? FILE_WR : 16'h0000);
  endtask
  initial begin
    #2000;
    errors++;
    conclude();
  end
  initial begin
    repeat (6) @(negedge CORE_CLK);
    RESETN = 1'b1;
    step(3'h1, 8'h0f, 7'h00, 5'h00, 8'h0f, 4'h0, 16'h0000);
    step(3'h2, 8'h01, 7'h7f, 5'h08, 8'h0f, 4'h2, 16'hff10);
    step(3'h2, 8'hf2, 7'h7f, 5'h00, 8'h01, 4'h3, 16'h0000);
    step(3'h4, 8'h55, 7'h05, 5'h18, 8'h01, 4'h3, 16'h8501);
    step(3'h3, 8'hfe, 7'h00, 5'h00, 8'h00, 4'h7, 16'h0000);
    $display("test arith done");
    step(3'h5, 8'hff, 7'h11, 5'h07, 8'h00, 4'h7, 16'h917f);
    step(3'h6, 8'h00, 7'h11, 5'h10, 8'h00, 4'h7, 16'h9101);
    step(3'h7, 8'hf7, 7'h22, 5'h03, 8'h00, 4'hf, 16'h0000);
    step(3'h1, 8'h01, 7'h00, 5'h00, 8'h00, 4'h7, 16'h0000);
    step(3'h7, 8'h08, 7'h22, 5'h03, 8'h00, 4'h7, 16'h0000);
    step(3'h1, 8'h01, 7'h00, 5'h00, 8'h01, 4'h0, 16'h0000);
    step(3'h1, 8'hff, 7'h00, 5'h00, 8'h00, 4'h7, 16'h0000);
    step(3'h0, 8'h5a, 7'h00, 5'h00, 8'h00, 4'h7, 16'h0000);
    $display("test bits done");
    conclude();
  end
endmodule
